// *** hw/ils_map.svh ***
`ifndef ILS_MAP_SVH
`define ILS_MAP_SVH
// Notes on behaviour
// RL1: 32 sources served through 20 vectors
// RL2: 17 peripheral requests need global mask clear
// RL3: Illegal opcode, trap, nonmaskable pin ignore mask
// RL4: Receive flag clears on status-then-data read
// RL5: Respond only at instruction boundary
// RL6: Push nine context bytes downward from SP
// RL7: After condition byte, set masks as needed
// RL8: Fetch highest-priority vector then continue there
// RL9: Reset sets both mask bits
// RL10: Nonmaskable mask clears once, never resets
// RL11: Nonmaskable pin outranks all maskable sources
// RL12: Maskable service sets global mask only
// RL13: Flag unimplemented opcodes on four pages
// RL14: Illegal trap stacks offending opcode address
// RL15: Software trap ignores masks, sets global mask
// RL16: Maskable pin is low-level wired-OR input
// RL17: Wait stacks, halts until unmasked request
// RL18: Wait reads condition byte address repeatedly
// RL19: Timer stops in wait if masked, watchdog off
// RL20: Stop halts clocks unless stop-disable set
// RL21: Stop exits on pin low, reset, edge request
// RL22: Nonmaskable pin always wakes; serviced if unmasked
// RL23: Delay enable set by reset; clearing it bypasses start-up delay
// RL24: Start-up delay length is a parameter
`define ILS_NUM_SRC        32
`define ILS_NUM_VEC        20
`define ILS_NUM_PERIPH     17
`define ILS_CC_STOP_BIT    7
`define ILS_CC_NMASK_BIT   6
`define ILS_CC_GMASK_BIT   4
`define ILS_VEC_PERIPH0    16'hFFD2
`define ILS_VEC_IRQPIN     16'hFFF2
`define ILS_VEC_NMIPIN     16'hFFF4
`define ILS_VEC_SWTRAP     16'hFFF6
`define ILS_VEC_ILLEGAL    16'hFFF8
`define ILS_STARTUP_CYC    4000
`endif

// *** hw/ils_pkg.sv ***
package ils_pkg;
  typedef enum logic [3:0] {
    ST_RUN   = 4'b0000,
    ST_PUSH  = 4'b0001,
    ST_VECHI = 4'b0010,
    ST_VECLO = 4'b0011,
    ST_WAIT  = 4'b0100,
    ST_STOP  = 4'b0101,
    ST_DELAY = 4'b0110
  } ils_state_t;
endpackage

// *** hw/ils_opcode_check.sv ***
`timescale 1ns/10ps
// Flags unimplemented opcodes on each of the four map pages
module ils_opcode_check (
  input  wire logic [1:0] page,
  input  wire logic [7:0] opcode,
  output logic            illegal
);
  always_comb
  begin
    illegal = 1'b0;
    case (page)
      2'd0: illegal = (opcode == 8'h00) || (opcode == 8'h41) || (opcode == 8'h42) || (opcode == 8'h45)
                   || (opcode == 8'h4B) || (opcode == 8'h4E) || (opcode == 8'h51) || (opcode == 8'h52)
                   || (opcode == 8'h55) || (opcode == 8'h5B) || (opcode == 8'h5E) || (opcode == 8'h61)
                   || (opcode == 8'h62) || (opcode == 8'h65) || (opcode == 8'h6B) || (opcode == 8'h71)
                   || (opcode == 8'h72) || (opcode == 8'h75) || (opcode == 8'h7B) || (opcode == 8'h87)
                   || (opcode == 8'h8F) || (opcode == 8'hC7) || (opcode == 8'hCD); // RL13
      2'd1: illegal = !((opcode[7:4] == 4'h0 && opcode[3:0] >= 4'h8 && opcode[3:0] <= 4'h9)
                   || (opcode[7:4] == 4'h1 && opcode[3:0] >= 4'hC && opcode[3:0] <= 4'hF)
                   || (opcode[7:4] == 4'h3 && (opcode[3:0] == 4'h0 || opcode[3:0] == 4'h5
                       || opcode[3:0] == 4'h8 || opcode[3:0] == 4'hA || opcode[3:0] == 4'hC))
                   || (opcode[7:4] >= 4'h6 && opcode[7:4] <= 4'h6)
                   || (opcode[7:4] == 4'hA) || (opcode[7:4] == 4'hE)
                   || (opcode[7:4] >= 4'h8 && opcode[3:0] == 4'hC)
                   || (opcode[7:4] >= 4'h8 && opcode[3:0] >= 4'hE)); // RL13
      2'd2: illegal = !(opcode == 8'hA3 || opcode == 8'hAC || opcode == 8'hEE || opcode == 8'hEF
                   || opcode == 8'hAE || opcode == 8'hAF || opcode == 8'hE3 || opcode == 8'hEC
                   || opcode == 8'hED); // RL13
      2'd3: illegal = !(opcode == 8'h83 || opcode == 8'h8C || opcode == 8'h93 || opcode == 8'h9C
                   || opcode == 8'hA3 || opcode == 8'hAC || opcode == 8'hB3 || opcode == 8'hBC
                   || opcode == 8'hCE || opcode == 8'hDE || opcode == 8'hDF || opcode == 8'hEE
                   || opcode == 8'hEF || opcode == 8'hFE || opcode == 8'hFF || opcode == 8'hAE
                   || opcode == 8'hAF || opcode == 8'hBE || opcode == 8'hBF); // RL13
      default: illegal = 1'b0;
    endcase
  end
endmodule // ils_opcode_check

// *** hw/ils_sequencer.sv ***
`timescale 1ns/10ps
`include "ils_map.svh"
module ils_sequencer #(
  parameter int STARTUP_CYC = `ILS_STARTUP_CYC // RL24
) (
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  input  wire logic                  porFlag,
  input  wire logic [16:0]           periphReq,
  input  wire logic                  maskReqPin,
  input  wire logic                  nmiReqPin,
  input  wire logic                  edgeReqPend,
  input  wire logic                  instrEnd,
  input  wire logic                  opFetch,
  input  wire logic [1:0]            opPage,
  input  wire logic [7:0]            opcode,
  input  wire logic [15:0]           opAddr,
  input  wire logic                  swTrapExec,
  input  wire logic                  waitExec,
  input  wire logic                  stopExec,
  input  wire logic                  ccWrite,
  input  wire logic [7:0]            ccWdata,
  input  wire logic [15:0]           regPc,
  input  wire logic [15:0]           regX,
  input  wire logic [15:0]           regY,
  input  wire logic [7:0]            regA,
  input  wire logic [7:0]            regB,
  input  wire logic [15:0]           regSp,
  input  wire logic [7:0]            busRdata,
  input  wire logic                  serStatRead,
  input  wire logic                  serDataRead,
  input  wire logic                  serRxDone,
  input  wire logic                  delayEnWr,
  input  wire logic                  delayEnData,
  input  wire logic                  watchdogDisable,
  output logic [7:0]                 ccReg,
  output logic [15:0]                busAddr,
  output logic [7:0]                 busWdata,
  output logic                       busWrite,
  output logic                       busRead,
  output logic                       cpuHold,
  output logic                       pcLoad,
  output logic [15:0]                pcValue,
  output logic [4:0]                 vecIndex,
  output logic                       timerHalt,
  output logic                       clocksOff,
  output logic                       receiveFull,
  output logic                       restartDelayEn
);
  import ils_pkg::*;

  ////////////////////////////////////////////////////////////////
  ils_state_t state;
  logic [1:0]  maskPinSync;
  logic [1:0]  nmiPinSync;
  logic [3:0]  pushCnt;
  logic [15:0] frameAddr;
  logic [15:0] vecAddr;
  logic [7:0]  vecHigh;
  logic [4:0]  vecSel;
  logic        srcNmi;
  logic        fromWait;
  logic        illegalPend;
  logic        statSeen;
  logic [15:0] trapPc;
  logic [12:0] delayCnt;
  logic        illegalOp;
  // Trap level stands only beside instrEnd; held until the next service entry reloads it
  logic        swTrapPend;

  ils_opcode_check opCheck (
    .page    (opPage),
    .opcode  (opcode),
    .illegal (illegalOp)
  );

  // Lowest set peripheral bit wins; index 0 has top rank
  function automatic logic [4:0] first_req(input logic [16:0] req);
    logic [4:0] idx;
    idx = 5'd31;
    for (int i = 16; i >= 0; i--)
      if (req[i])
        idx = 5'(i);
    return idx;
  endfunction

  function automatic logic [7:0] push_byte(input logic [3:0] n);
    case (n)
      4'd0: return regPc[7:0];
      4'd1: return regPc[15:8];
      4'd2: return regY[7:0];
      4'd3: return regY[15:8];
      4'd4: return regX[7:0];
      4'd5: return regX[15:8];
      4'd6: return regA;
      4'd7: return regB;
      default: return ccReg;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////
  // Pins come from outside: two flops before use
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      maskPinSync <= 2'b11;
      nmiPinSync  <= 2'b11;
    end
    else
    begin
      maskPinSync <= {maskPinSync[0], maskReqPin};
      nmiPinSync  <= {nmiPinSync[0], nmiReqPin};
    end
  end

  logic maskPinLow;
  logic nmiPinLow;
  logic gmask;
  logic nmask;
  logic maskableAny;
  logic nmiServe;
  assign maskPinLow  = !maskPinSync[1]; // RL16
  assign nmiPinLow   = !nmiPinSync[1];
  assign gmask       = ccReg[`ILS_CC_GMASK_BIT];
  assign nmask       = ccReg[`ILS_CC_NMASK_BIT];
  assign maskableAny = !gmask && ((|periphReq) || maskPinLow || edgeReqPend); // RL2
  assign nmiServe    = nmiPinLow && !nmask; // RL3

  ////////////////////////////////////////////////////////////////
  // Illegal opcode capture keeps the first byte address
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      illegalPend <= 1'b0;
      trapPc      <= 16'h0000;
    end
    else if (opFetch && illegalOp && state == ST_RUN)
    begin
      illegalPend <= 1'b1; // RL13
      trapPc      <= opAddr; // RL14
    end
    // Cleared only once the vector is chosen, so the pick still sees it
    else if (state == ST_VECHI)
      illegalPend <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // Receive flag: set by hardware wins over a clearing read
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      receiveFull <= 1'b0;
      statSeen    <= 1'b0;
    end
    else
    begin
      if (serStatRead)
        statSeen <= receiveFull;
      else if (serDataRead)
        statSeen <= 1'b0;
      if (serRxDone)
        receiveFull <= 1'b1;
      else if (serDataRead && statSeen)
        receiveFull <= 1'b0; // RL4
    end
  end

  ////////////////////////////////////////////////////////////////
  // Restart delay enable
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      restartDelayEn <= 1'b1; // RL23
    else if (delayEnWr)
      restartDelayEn <= delayEnData;
  end

  ////////////////////////////////////////////////////////////////
  // Main sequencer and condition code register
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      state     <= ST_RUN;
      ccReg     <= 8'hD0; // RL9
      pushCnt   <= 4'd0;
      frameAddr <= 16'h0000;
      vecAddr   <= 16'h0000;
      vecHigh   <= 8'h00;
      vecSel    <= 5'd0;
      srcNmi    <= 1'b0;
      fromWait  <= 1'b0;
      swTrapPend <= 1'b0;
      busAddr   <= 16'h0000;
      busWdata  <= 8'h00;
      busWrite  <= 1'b0;
      busRead   <= 1'b0;
      cpuHold   <= 1'b0;
      pcLoad    <= 1'b0;
      pcValue   <= 16'h0000;
      vecIndex  <= 5'd0;
      timerHalt <= 1'b0;
      clocksOff <= 1'b0;
      delayCnt  <= 13'd0;
    end
    else
    begin
      busWrite <= 1'b0;
      busRead  <= 1'b0;
      pcLoad   <= 1'b0;
      case (state)
        ST_RUN:
        begin
          // Software may only clear the nonmaskable bit, never set it
          if (ccWrite)
          begin
            ccReg <= ccWdata;
            ccReg[`ILS_CC_NMASK_BIT] <= nmask & ccWdata[`ILS_CC_NMASK_BIT]; // RL10
          end
          if (instrEnd) // RL5
          begin
            if (waitExec || nmiServe || illegalPend || swTrapExec || maskableAny)
            begin
              state     <= ST_PUSH;
              pushCnt   <= 4'd0;
              frameAddr <= regSp; // RL6
              fromWait  <= waitExec;
              swTrapPend <= swTrapExec; // RL15
              cpuHold   <= 1'b1;
            end
            else if (stopExec && !ccReg[`ILS_CC_STOP_BIT]) // RL20
            begin
              state     <= ST_STOP;
              cpuHold   <= 1'b1;
              clocksOff <= 1'b1;
            end
          end
        end
        ST_PUSH:
        begin
          busWrite <= 1'b1;
          busAddr  <= frameAddr - 16'(pushCnt); // RL6
          // Illegal trap returns to the faulting opcode, not past it
          busWdata <= (pushCnt < 4'd2 && illegalPend && !fromWait)
                      ? (pushCnt == 4'd0 ? trapPc[7:0] : trapPc[15:8]) : push_byte(pushCnt); // RL14
          if (pushCnt == 4'd8)
          begin
            if (fromWait)
            begin
              state   <= ST_WAIT; // RL17
              timerHalt <= gmask && watchdogDisable; // RL19
            end
            else
              state <= ST_VECHI;
          end
          else
            pushCnt <= pushCnt + 4'd1;
        end
        ST_WAIT:
        begin
          // Bus keeps reading the stacked condition byte, never writes
          busRead <= 1'b1;
          busAddr <= frameAddr - 16'd8; // RL18
          if (nmiServe || maskableAny)
          begin
            timerHalt <= 1'b0;
            fromWait  <= 1'b0;
            state     <= ST_VECHI;
          end
        end
        ST_VECHI:
        begin
          // Choose source and set masks once the frame is stacked
          srcNmi <= 1'b0;
          if (illegalPend)
            vecAddr <= `ILS_VEC_ILLEGAL; // RL3
          else if (swTrapPend)
            vecAddr <= `ILS_VEC_SWTRAP; // RL15
          else if (nmiServe) // RL11
          begin
            vecAddr <= `ILS_VEC_NMIPIN;
            srcNmi  <= 1'b1;
            ccReg[`ILS_CC_NMASK_BIT] <= 1'b1; // RL7
          end
          else if (maskPinLow || edgeReqPend)
            vecAddr <= `ILS_VEC_IRQPIN;
          else
            vecAddr <= `ILS_VEC_PERIPH0 + {10'd0, first_req(periphReq), 1'b0}; // RL1
          vecSel   <= first_req(periphReq);
          ccReg[`ILS_CC_GMASK_BIT] <= 1'b1; // RL12
          state    <= ST_VECLO;
          pushCnt  <= 4'd0;
        end
        ST_VECLO:
        begin
          // Two reads: high byte then low byte; data lag the strobe by one cycle
          vecIndex <= srcNmi ? 5'd18 : vecSel;
          if (pushCnt < 4'd2)
          begin
            busRead <= 1'b1;
            busAddr <= vecAddr + 16'(pushCnt);
          end
          if (pushCnt == 4'd2)
            vecHigh <= busRdata;
          if (pushCnt == 4'd3)
          begin
            pcValue <= {vecHigh, busRdata}; // RL8
            pcLoad  <= 1'b1;
            cpuHold <= 1'b0;
            state   <= ST_RUN;
          end
          else
            pushCnt <= pushCnt + 4'd1;
        end
        ST_STOP:
        begin
          // With the delay off the core gets control back at once
          if (nmiPinLow || (maskPinLow && !gmask) || (edgeReqPend && !gmask)) // RL21 RL22
          begin
            clocksOff <= 1'b0;
            delayCnt  <= 13'd0;
            state     <= restartDelayEn ? ST_DELAY : ST_RUN; // RL23
            cpuHold   <= restartDelayEn;
          end
        end
        ST_DELAY:
        begin
          // Clocks run again, core held until the oscillator settles
          delayCnt <= delayCnt + 13'd1;
          if (delayCnt == 13'(STARTUP_CYC - 1))
          begin
            state   <= ST_RUN; // RL24
            cpuHold <= 1'b0;
          end
        end
        default: state <= ST_RUN;
      endcase
    end
  end
endmodule // ils_sequencer

// *** sim/ils_seq_properties.sv ***
`timescale 1ns/10ps
module ils_seq_properties (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        instrEnd,
  input wire logic        stopExec,
  input wire logic        watchdogDisable,
  input wire logic [7:0]  ccReg,
  input wire logic [15:0] busAddr,
  input wire logic        busWrite,
  input wire logic        busRead,
  input wire logic        cpuHold,
  input wire logic        pcLoad,
  input wire logic        timerHalt,
  input wire logic        clocksOff,
  input wire logic        restartDelayEn
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Length of the current run of bus writes
  logic [3:0] wrRun;
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      wrRun <= 4'h0;
    else if (busWrite)
      wrRun <= wrRun + 4'h1;
    else
      wrRun <= 4'h0;
  end
////////////////////////////////////////////////////////////////////////////////
  a_reset_masks: assert property ($rose(nrst) |-> ccReg == 8'hD0 && restartDelayEn)
    else $error("masks or delay enable wrong after reset");
  a_nmask_sticky: assert property (!ccReg[6] && !cpuHold |=> !ccReg[6])
    else $error("nonmask mask set again");
  a_stack_len: assert property ($fell(busWrite) |-> wrRun == 4'h9)
    else $error("stacking is not nine writes");
  a_stack_max: assert property (busWrite |-> wrRun <= 4'h8)
    else $error("stacking runs past nine writes");
  a_stack_addr: assert property ($rose(busWrite) |-> ##8 busAddr == $past(busAddr, 8) - 16'h0008)
    else $error("stacking does not end eight below start");
  a_mask_entry: assert property (pcLoad |-> ccReg[4])
    else $error("global mask clear at vector load");
  a_load_pulse: assert property (pcLoad |=> !pcLoad)
    else $error("vector load longer than one cycle");
  a_timer_gate: assert property (timerHalt |-> ccReg[4] && watchdogDisable)
    else $error("timer halted without both bits");
  a_stop_nop: assert property (instrEnd && stopExec && ccReg[7] && !cpuHold |=> !clocksOff[*3])
    else $error("stop taken while disabled");
  c_service: cover property (pcLoad);
  c_wait: cover property (busRead && cpuHold);
  c_wake: cover property ($fell(clocksOff));
endmodule // ils_seq_properties

bind ils_sequencer ils_seq_properties u_props (
  .core_clk(core_clk), .nrst(nrst), .instrEnd(instrEnd), .stopExec(stopExec),
  .watchdogDisable(watchdogDisable), .ccReg(ccReg), .busAddr(busAddr), .busWrite(busWrite),
  .busRead(busRead), .cpuHold(cpuHold), .pcLoad(pcLoad), .timerHalt(timerHalt),
  .clocksOff(clocksOff), .restartDelayEn(restartDelayEn)
);

// *** sim/ils_far_model.sv ***
`timescale 1ns/10ps
module ils_far_model (
  input  wire logic        core_clk,
  input  wire logic [1:0]  irqSrc,
  input  wire logic        nmiWant,
  input  wire logic [16:0] periphWant,
  input  wire logic        busRead,
  input  wire logic [15:0] busAddr,
  output logic [16:0]      periphReq,
  output logic             maskReqPin,
  output logic             nmiReqPin,
  output logic [7:0]       busRdata
);
  // Pull-up pins: any source pulls the wire low
  assign maskReqPin = ~(|irqSrc);
  assign nmiReqPin  = ~nmiWant;
  assign periphReq  = periphWant;
  // Answer one cycle after a read, else flip so stale data never matches
  always_ff @(posedge core_clk)
  begin
    if (busRead)
      busRdata <= busAddr[7:0] ^ 8'h3C;
    else
      busRdata <= ~busRdata;
  end
endmodule // ils_far_model

// *** sim/ils_sequencer_bench.sv ***
`timescale 1ns/10ps
module ils_sequencer_bench;
  logic        core_clk, nrst, porFlag, edgeReqPend, instrEnd, opFetch, swTrapExec, waitExec, stopExec;
  logic        delayEnData, watchdogDisable, maskReqPin, nmiReqPin, nmiWant, busWrite, busRead, cpuHold;
  logic        pcLoad, timerHalt, clocksOff, receiveFull, restartDelayEn;
  logic [1:0]  opPage, irqSrc;
  logic [4:0]  strb, vecIndex;
  logic [7:0]  opcode, ccWdata, regA, regB, busRdata, ccReg, busWdata;
  logic [15:0] opAddr, regPc, regX, regY, regSp, busAddr, pcValue;
  logic [16:0] periphReq, periphWant;
  int          errTotal, checksDone;

  ils_sequencer #(.STARTUP_CYC(8)) u_dut (
    .core_clk, .nrst, .porFlag, .periphReq, .maskReqPin, .nmiReqPin, .edgeReqPend, .instrEnd, .opFetch,
    .opPage, .opcode, .opAddr, .swTrapExec, .waitExec, .stopExec, .ccWrite(strb[3]), .ccWdata, .regPc,
    .regX, .regY, .regA, .regB, .regSp, .busRdata, .serStatRead(strb[1]), .serDataRead(strb[2]),
    .serRxDone(strb[0]), .delayEnWr(strb[4]), .delayEnData, .watchdogDisable, .ccReg, .busAddr,
    .busWdata, .busWrite, .busRead, .cpuHold, .pcLoad, .pcValue, .vecIndex, .timerHalt, .clocksOff,
    .receiveFull, .restartDelayEn
  );
  ils_far_model u_far (
    .core_clk, .irqSrc, .nmiWant, .periphWant, .busRead, .busAddr, .periphReq, .maskReqPin,
    .nmiReqPin, .busRdata
  );

  always #12.5 core_clk = ~core_clk;
////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic note(input string s);
    $display("test %s done", s);
  endtask

  task automatic wrapUp();
    $display("checks %0d mismatches %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic strobe(input int i);
    @(posedge core_clk);
    strb[i] <= 1'b1;
    @(posedge core_clk);
    strb[i] <= 1'b0;
    #1;
  endtask

  task automatic ccSet(input logic [7:0] v);
    ccWdata <= v;
    strobe(3);
    settle(1);
  endtask

  task automatic endInstr(input logic sw, input logic wt, input logic sp);
    @(posedge core_clk);
    {instrEnd, swTrapExec, waitExec, stopExec} <= {1'b1, sw, wt, sp};
    @(posedge core_clk);
    {instrEnd, swTrapExec, waitExec, stopExec} <= 4'h0;
  endtask

  // Stacked bytes and vector fetch; in wait, a request is raised after four idle reads
  task automatic entry(input logic sw, input logic wt, input logic [15:0] vec);
    logic [7:0] stk [9];
    int         n;
    int         rd;
    stk = '{8'h34, 8'h12, 8'h78, 8'h56, 8'hBC, 8'h9A, 8'hDE, 8'hF0, ccReg};
    n = 0;
    rd = 0;
    endInstr(sw, wt, 1'b0);
    repeat (80)
    begin
      settle(1);
      if (busWrite && n < 9)
      begin
        chk(busAddr, regSp - n[15:0]);
        chk(busWdata, stk[n]);
        n++;
      end
      if (wt && busRead && rd < 4)
      begin
        chk(busAddr, regSp - 16'h0008);
        chk(timerHalt, 1'b0);
        rd++;
        if (rd == 4)
          periphWant[5] <= 1'b1;
      end
      if (pcLoad)
      begin
        chk(pcValue, {vec[7:0] ^ 8'h3C, (vec[7:0] + 8'h01) ^ 8'h3C});
        break;
      end
    end
    chk(pcLoad, 1'b1);
    chk(n[15:0], 16'h0009);
  endtask
////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #150000;
    errTotal++;
    $display("watchdog expired");
    wrapUp();
  end

  initial
  begin
    {core_clk, nrst, edgeReqPend, instrEnd, opFetch, swTrapExec, waitExec, stopExec, delayEnData} = '0;
    {nmiWant, opPage, irqSrc, strb, opcode, ccWdata, opAddr, periphWant, errTotal, checksDone} = '0;
    porFlag = 1'b1;
    watchdogDisable = 1'b1;
    {regPc, regY, regX, regA, regB, regSp} = {16'h1234, 16'h5678, 16'h9ABC, 8'hDE, 8'hF0, 16'h01FF};
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    porFlag <= 1'b0;
    settle(1);
    chk(ccReg, 8'hD0);
    chk(restartDelayEn, 1'b1);
    note("reset");
    strobe(0);
    strobe(2);
    settle(1);
    chk(receiveFull, 1'b1);
    strobe(1);
    strobe(2);
    settle(1);
    chk(receiveFull, 1'b0);
    note("receive flag");
    nmiWant <= 1'b1;
    settle(3);
    endInstr(1'b0, 1'b0, 1'b0);
    settle(4);
    chk(cpuHold, 1'b0);
    ccSet(8'h00);
    chk(ccReg[6], 1'b0);
    ccSet(8'hFF);
    chk(ccReg[6], 1'b0);
    ccSet(8'h00);
    periphWant[3] <= 1'b1;
    irqSrc <= 2'b01;
    settle(3);
    entry(1'b0, 1'b0, 16'hFFF4);
    settle(1);
    chk(ccReg[6], 1'b1);
    chk(ccReg[4], 1'b1);
    nmiWant <= 1'b0;
    settle(3);
    ccSet(8'h00);
    entry(1'b0, 1'b0, 16'hFFF2);
    settle(1);
    chk(ccReg[6], 1'b0);
    chk(ccReg[4], 1'b1);
    irqSrc <= 2'b10;
    settle(3);
    endInstr(1'b0, 1'b0, 1'b0);
    settle(4);
    chk(cpuHold, 1'b0);
    entry(1'b1, 1'b0, 16'hFFF6);
    opcode <= 8'h41;
    opAddr <= 16'h1234;
    regPc  <= 16'h1236;
    @(posedge core_clk);
    opFetch <= 1'b1;
    @(posedge core_clk);
    opFetch <= 1'b0;
    entry(1'b0, 1'b0, 16'hFFF8);
    regPc <= 16'h1234;
    note("service");
    irqSrc <= 2'b00;
    periphWant <= '0;
    ccSet(8'h00);
    entry(1'b0, 1'b1, 16'hFFDC);
    chk(vecIndex, 16'h0005);
    periphWant <= '0;
    note("wait");
    ccSet(8'h80);
    endInstr(1'b0, 1'b0, 1'b1);
    settle(3);
    chk(clocksOff, 1'b0);
    ccSet(8'h00);
    endInstr(1'b0, 1'b0, 1'b1);
    settle(3);
    chk(clocksOff, 1'b1);
    edgeReqPend <= 1'b1;
    repeat (40)
    begin
      settle(1);
      if (clocksOff === 1'b0)
        break;
    end
    chk(clocksOff, 1'b0);
    settle(7);
    chk(cpuHold, 1'b1);
    settle(1);
    chk(cpuHold, 1'b0);
    edgeReqPend <= 1'b0;
    strobe(4);
    settle(1);
    chk(restartDelayEn, 1'b0);
    endInstr(1'b0, 1'b0, 1'b1);
    settle(2);
    chk(clocksOff, 1'b1);
    edgeReqPend <= 1'b1;
    settle(1);
    chk(clocksOff, 1'b0);
    chk(cpuHold, 1'b0);
    edgeReqPend <= 1'b0;
    note("stop");
    wrapUp();
  end
endmodule // ils_sequencer_bench
